// ### pkg/side_pin_defines.svh
// Constants for the side control pin function multiplexer.
// Assumes a 100 MHz system clock; included by the package file, whose macros the design files use.
`ifndef SIDE_PIN_DEFINES_SVH
`define SIDE_PIN_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define ADDR_PIN_FUNC      8'h00
`define ADDR_PIN_POLARITY  8'h04
`define ADDR_PIN_DRIVE     8'h08
`define ADDR_GPIO_OUT      8'h0C
`define ADDR_GPIO_DIR      8'h10
`define ADDR_GPIO_IN       8'h14
`define ADDR_BB_CTRL       8'h18
`define ADDR_BB_DATA       8'h1C
`define ADDR_BB_READBACK   8'h20
`define ADDR_LED_STRETCH   8'h24
`define ADDR_STATUS        8'h28
`define ADDR_CHIP_ID       8'h2C

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define FUNC_W             4
`define PIN_COUNT          5
`define GPIO_COUNT         4
`define BB_MODE_LSB        0
`define BB_DIV_LSB         8
`define BB_DIV_W           14
`define STRETCH_W          20
`define ST_BB_FULL         0
`define ST_BB_READY        1
`define ST_SUSPEND         2
`define ST_CONFIGURED      3
`define ST_GPIO_LSB        4

// ----------------------------------------------------------------------------
// Reset values: factory defaults pin0..pin4
// ----------------------------------------------------------------------------
`define FUNC_RESET         20'h51032
`define STRETCH_RESET      20'h186A0
`define BB_DIV_RESET       14'h0064
`define CHIP_ID_VALUE      32'h5A5A1234

// ----------------------------------------------------------------------------
// Clock divider: 100 MHz base, divide counts for the four clock outputs
// ----------------------------------------------------------------------------
`define CLK_MHZ            100
`define CLKDIV_W           4
`define HALF_48            4'h1
`define HALF_24            4'h2
`define HALF_12            4'h4
`define HALF_6             4'h8

`endif

// ### pkg/side_pin_pkg.sv
// Types shared by the side control pin multiplexer files.
// Assumes the constants header sits in the same include path.
`include "side_pin_defines.svh"
package side_pin_pkg;

  typedef enum logic [3:0] {
    FN_DRIVE_EN   = 4'h0,
    FN_POWER_EN   = 4'h1,
    FN_OUT_LED    = 4'h2,
    FN_IN_LED     = 4'h3,
    FN_ACT_LED    = 4'h4,
    FN_SUSPEND    = 4'h5,
    FN_CLOCK_OUT_48      = 4'h6,
    FN_CLOCK_OUT_24      = 4'h7,
    FN_CLOCK_OUT_12      = 4'h8,
    FN_CLOCK_OUT_6       = 4'h9,
    FN_GPIO       = 4'hA,
    FN_WR_STROBE  = 4'hB,
    FN_RD_STROBE  = 4'hC
  } pin_func_type;

  typedef enum logic [1:0] {
    BB_OFF   = 2'h0,
    BB_ASYNC = 2'h1,
    BB_SYNC  = 2'h2
  } bb_mode_type;

  typedef struct packed {
    logic host_configured;
    logic suspend;
    logic host_out_xfer;
    logic host_in_xfer;
    logic uart_tx_busy;
    logic uart_tx_pending;
  } usb_state_type;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } port_drive_type;

endpackage

// ### hdl/clock_out_divider.sv
// Derives the four side-pin clock output waveforms from the system clock.
// Assumes one system clock; waveforms are held low while suspend is high.
`timescale 1ns/1ns
module clock_out_divider
  import side_pin_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       suspend_in,
  output logic      [3:0] clk_wave_out
);

  localparam logic [`CLKDIV_W-1:0] HALF [4] = '{`HALF_6, `HALF_12, `HALF_24, `HALF_48};

  // ----------------------------------------------------------------------------
  // One divider per output rate
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_div
      logic [`CLKDIV_W-1:0] cnt_r;
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cnt_r <= '0;
          clk_wave_out[g] <= 1'b0;
        end else if (suspend_in) begin
          cnt_r <= '0;
          clk_wave_out[g] <= 1'b0;
        end else if (cnt_r >= HALF[g] - 1'b1) begin
          cnt_r <= '0;
          clk_wave_out[g] <= ~clk_wave_out[g];
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  endgenerate

endmodule

// ### hdl/side_pin_function_mux.sv
// Side control pin function multiplexer with bit-bang parallel port.
// Assumes an AHB-Lite master on clk_sys_in; USB state inputs come from
// same-clock logic, pin inputs are asynchronous and are synchronised here.
// Function
// - Five side pins, each function chosen from stored configuration.
// - Each pin carries exactly one selected function at a time.
// - Per-pin inversion and drive strength selectable from configuration.
// - RS485 drive enable on any pin while serial data transmits.
// - Power enable low once configured, high during suspend.
// - Host-out LED pulses low on host-to-device transfers.
// - Host-in LED pulses low on device-to-host transfers.
// - Activity LED pulses low on transfer in either direction.
// - Suspend indicator low throughout suspend, high otherwise.
// - Clock outputs of 48, 24, 12 or 6 MHz on any pin; from the 100 MHz clock the dividers give 50, 25, 12.5 and 6.25 MHz.
// - Clock outputs stop toggling during suspend.
// - General-purpose I/O only on pins 0 to 3.
// - General-purpose pins work independently of UART traffic.
// - Write strobe only on pins 0 and 1, both bit-bang modes.
// - Read strobe only on pins 0 to 3, both bit-bang modes.
// - Bit-bang turns eight UART lines into an 8-bit parallel port.
// - Async bit-bang outputs bytes in turn, paced by internal timer.
// - Port read and write strobes appear on side pins.
// - Sync bit-bang samples port pins only when a write occurs.
// - Fixed unique identification number, read-only.
// - Pin 4 output-only; factory default is the suspend indicator.
`timescale 1ns/1ns
module side_pin_function_mux
  import side_pin_pkg::*;
#(
  parameter int unsigned STRETCH_W = `STRETCH_W
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic         hsel_in,
  input  wire logic  [31:0] haddr_in,
  input  wire logic  [1:0]  htrans_in,
  input  wire logic         hwrite_in,
  input  wire logic  [2:0]  hsize_in,
  input  wire logic  [31:0] hwdata_in,
  input  wire logic         hready_in,
  output logic       [31:0] hrdata_out,
  output logic              hreadyout_out,
  output logic              hresp_out,
  input  wire usb_state_type usb_state_in,
  input  wire logic  [7:0]  uart_line_out_in,
  input  wire logic  [7:0]  uart_line_oe_in,
  input  wire logic  [7:0]  port_pin_in,
  output logic       [7:0]  port_pin_out,
  output logic       [7:0]  port_pin_oe_out,
  input  wire logic  [3:0]  side_pin_in,
  output logic       [4:0]  side_pin_out,
  output logic       [4:0]  side_pin_oe_out,
  output logic       [4:0]  side_pin_drive_out
);

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  logic [`PIN_COUNT*`FUNC_W-1:0] pin_func_r;
  logic [`PIN_COUNT-1:0]         pin_pol_r;
  logic [`PIN_COUNT-1:0]         pin_drive_r;
  logic [`GPIO_COUNT-1:0]        gpio_out_r;
  logic [`GPIO_COUNT-1:0]        gpio_dir_r;
  bb_mode_type                   bb_mode_r;
  logic [`BB_DIV_W-1:0]          bb_div_r;
  logic [7:0]                    bb_dir_r;
  logic [STRETCH_W-1:0]          stretch_r;

  // Bit-bang data path
  logic [7:0] bb_data_r;
  logic       bb_full_r;
  logic [7:0] bb_out_r;
  logic [7:0] bb_readback_r;
  logic       bb_ready_r;
  logic [`BB_DIV_W-1:0] bb_tick_r;
  logic       wr_strobe_r;
  logic       rd_strobe_r;

  // ----------------------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------------------
  logic [11:0] pin_meta_r;
  logic [11:0] pin_sync_r;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {side_pin_in, port_pin_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------------------
  // AHB-Lite slave: one address phase register, zero wait states
  // ----------------------------------------------------------------------------
  logic       dp_wr_r;
  logic       dp_rd_r;
  logic [7:0] dp_addr_r;
  logic       ap_valid;
  assign ap_valid = hsel_in && hready_in && htrans_in[1];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= '0;
    end else if (hready_in) begin
      dp_wr_r   <= ap_valid && hwrite_in;
      dp_rd_r   <= ap_valid && !hwrite_in;
      dp_addr_r <= haddr_in[7:0];
    end
  end

  logic bb_wr_evt;
  logic bb_rd_evt;
  assign bb_wr_evt = dp_wr_r && dp_addr_r == `ADDR_BB_DATA && !bb_full_r;
  assign bb_rd_evt = dp_rd_r && dp_addr_r == `ADDR_BB_READBACK;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_func_r  <= `FUNC_RESET;
      pin_pol_r   <= '0;
      pin_drive_r <= '0;
      gpio_out_r  <= '0;
      gpio_dir_r  <= '0;
      bb_mode_r   <= BB_OFF;
      bb_div_r    <= `BB_DIV_RESET;
      bb_dir_r    <= '0;
      stretch_r   <= STRETCH_W'(`STRETCH_RESET);
    end else if (dp_wr_r) begin
      unique case (dp_addr_r)
        `ADDR_PIN_FUNC:     pin_func_r  <= hwdata_in[`PIN_COUNT*`FUNC_W-1:0];
        `ADDR_PIN_POLARITY: pin_pol_r   <= hwdata_in[`PIN_COUNT-1:0];
        `ADDR_PIN_DRIVE:    pin_drive_r <= hwdata_in[`PIN_COUNT-1:0];
        `ADDR_GPIO_OUT:     gpio_out_r  <= hwdata_in[`GPIO_COUNT-1:0];
        `ADDR_GPIO_DIR:     gpio_dir_r  <= hwdata_in[`GPIO_COUNT-1:0];
        `ADDR_BB_CTRL: begin
          bb_mode_r <= bb_mode_type'(hwdata_in[`BB_MODE_LSB +: 2]);
          bb_div_r  <= hwdata_in[`BB_DIV_LSB +: `BB_DIV_W];
          bb_dir_r  <= hwdata_in[31:24];
        end
        `ADDR_LED_STRETCH:  stretch_r   <= hwdata_in[STRETCH_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Bit-bang engine
  // ----------------------------------------------------------------------------
  // Async mode drains the held byte on the pacing tick; sync mode applies at once
  logic bb_tick;
  assign bb_tick = bb_tick_r == '0;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bb_tick_r <= '0;
    end else if (bb_tick || bb_mode_r != BB_ASYNC) begin
      bb_tick_r <= bb_div_r;
    end else begin
      bb_tick_r <= bb_tick_r - 1'b1;
    end
  end

  logic bb_apply;
  assign bb_apply = bb_full_r && (bb_mode_r == BB_SYNC || (bb_mode_r == BB_ASYNC && bb_tick));

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bb_data_r <= '0;
      bb_full_r <= 1'b0;
      bb_out_r  <= '0;
    end else begin
      if (bb_wr_evt) begin
        bb_data_r <= hwdata_in[7:0];
      end
      // A byte only lands while empty; set wins over clear when it lands with the mode off
      if (bb_wr_evt) begin
        bb_full_r <= 1'b1;
      end else if (bb_apply || bb_mode_r == BB_OFF) begin
        bb_full_r <= 1'b0;
      end
      if (bb_apply) begin
        bb_out_r <= bb_data_r;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bb_readback_r <= '0;
      bb_ready_r    <= 1'b0;
    end else begin
      if ((bb_mode_r == BB_SYNC && bb_apply) || bb_mode_r == BB_ASYNC) begin
        bb_readback_r <= pin_sync_r[7:0];
      end
      if (bb_mode_r == BB_SYNC && bb_apply) begin
        bb_ready_r <= 1'b1;
      end else if (bb_rd_evt) begin
        bb_ready_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_strobe_r <= 1'b0;
      rd_strobe_r <= 1'b0;
    end else begin
      wr_strobe_r <= bb_apply;
      rd_strobe_r <= bb_rd_evt && bb_mode_r != BB_OFF;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_pin_out    <= '0;
      port_pin_oe_out <= '0;
    end else if (bb_mode_r != BB_OFF) begin
      port_pin_out    <= bb_out_r;
      port_pin_oe_out <= bb_dir_r;
    end else begin
      port_pin_out    <= uart_line_out_in;
      port_pin_oe_out <= uart_line_oe_in;
    end
  end

  // ----------------------------------------------------------------------------
  // LED stretchers
  // ----------------------------------------------------------------------------
  logic [2:0] led_evt;
  logic [2:0] led_on;
  assign led_evt = {usb_state_in.host_out_xfer || usb_state_in.host_in_xfer,
                    usb_state_in.host_in_xfer, usb_state_in.host_out_xfer};

  genvar l;
  generate
    for (l = 0; l < 3; l++) begin : gen_led
      logic [STRETCH_W-1:0] cnt_r;
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cnt_r <= '0;
        end else if (led_evt[l]) begin
          cnt_r <= stretch_r;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
      assign led_on[l] = cnt_r != '0;
    end
  endgenerate

  logic drive_en;
  assign drive_en = usb_state_in.uart_tx_busy || usb_state_in.uart_tx_pending;

  // ----------------------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------------------
  logic [3:0] clk_wave;
  clock_out_divider u_clkdiv (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .suspend_in   (usb_state_in.suspend),
    .clk_wave_out (clk_wave)
  );

  // ----------------------------------------------------------------------------
  // Per-pin function selection
  // ----------------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < `PIN_COUNT; p++) begin : gen_pin
      pin_func_type fn;
      logic         lvl;
      logic         oe;
      assign fn = pin_func_type'(pin_func_r[p*`FUNC_W +: `FUNC_W]);
      always_comb begin
        lvl = 1'b1;
        oe  = 1'b1;
        case (fn)
          FN_DRIVE_EN:  lvl = drive_en;
          FN_POWER_EN:  lvl = !(usb_state_in.host_configured && !usb_state_in.suspend);
          FN_OUT_LED:   lvl = !led_on[0];
          FN_IN_LED:    lvl = !led_on[1];
          FN_ACT_LED:   lvl = !led_on[2];
          FN_SUSPEND:   lvl = !usb_state_in.suspend;
          FN_CLOCK_OUT_48:     lvl = clk_wave[3];
          FN_CLOCK_OUT_24:     lvl = clk_wave[2];
          FN_CLOCK_OUT_12:     lvl = clk_wave[1];
          FN_CLOCK_OUT_6:      lvl = clk_wave[0];
          // GPIO pins 0-3 only; pin 4 never an input
          FN_GPIO: begin
            if (p < `GPIO_COUNT) begin
              lvl = gpio_out_r[p % `GPIO_COUNT];
              oe  = gpio_dir_r[p % `GPIO_COUNT];
            end
          end
          FN_WR_STROBE: lvl = (p < 2) ? !wr_strobe_r : 1'b1;
          FN_RD_STROBE: lvl = (p < 4) ? !rd_strobe_r : 1'b1;
          default:      lvl = 1'b1;
        endcase
      end
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          side_pin_out[p]       <= 1'b1;
          side_pin_oe_out[p]    <= 1'b0;
          side_pin_drive_out[p] <= 1'b0;
        end else begin
          side_pin_out[p]       <= lvl ^ pin_pol_r[p];
          side_pin_oe_out[p]    <= oe;
          side_pin_drive_out[p] <= pin_drive_r[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------------------
  // Identification is a constant
  localparam logic [31:0] CHIP_ID = `CHIP_ID_VALUE;

  logic [31:0] rd_mux;
  logic [31:0] status;
  // GPIO inputs read regardless of UART
  assign status = {24'h000000, pin_sync_r[11:8], usb_state_in.host_configured,
                   usb_state_in.suspend, bb_ready_r, bb_full_r};

  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr_in[7:0])
      `ADDR_PIN_FUNC:     rd_mux[`PIN_COUNT*`FUNC_W-1:0] = pin_func_r;
      `ADDR_PIN_POLARITY: rd_mux[`PIN_COUNT-1:0] = pin_pol_r;
      `ADDR_PIN_DRIVE:    rd_mux[`PIN_COUNT-1:0] = pin_drive_r;
      `ADDR_GPIO_OUT:     rd_mux[`GPIO_COUNT-1:0] = gpio_out_r;
      `ADDR_GPIO_DIR:     rd_mux[`GPIO_COUNT-1:0] = gpio_dir_r;
      `ADDR_GPIO_IN:      rd_mux[`GPIO_COUNT-1:0] = pin_sync_r[11:8];
      `ADDR_BB_CTRL:      rd_mux = {bb_dir_r, 2'b00, bb_div_r, 6'h00, bb_mode_r};
      `ADDR_BB_DATA:      rd_mux[7:0] = bb_data_r;
      `ADDR_BB_READBACK:  rd_mux[7:0] = bb_readback_r;
      `ADDR_LED_STRETCH:  rd_mux[STRETCH_W-1:0] = stretch_r;
      `ADDR_STATUS:       rd_mux = status;
      `ADDR_CHIP_ID:      rd_mux = CHIP_ID;
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Read data registered at the address phase so it stands in the data phase
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out    <= '0;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else if (ap_valid && !hwrite_in) begin
      hrdata_out <= rd_mux;
    end
  end

endmodule

// ### tb/side_pin_chk.sv
// Port checker for the side pin multiplexer.
// Assumes it is bound onto side_pin_function_mux and sees only its ports.
`timescale 1ns/1ns
module side_pin_chk
  import side_pin_pkg::*;
(
  input  wire logic          clk_sys_in,
  input  wire logic          rst_n_in,
  input  wire logic          hsel_in,
  input  wire logic  [1:0]   htrans_in,
  input  wire logic          hwrite_in,
  input  wire logic          hready_in,
  input  wire logic  [31:0]  hrdata_out,
  input  wire logic          hreadyout_out,
  input  wire logic          hresp_out,
  input  wire usb_state_type usb_state_in,
  input  wire logic  [7:0]   port_pin_out,
  input  wire logic  [4:0]   side_pin_out,
  input  wire logic  [4:0]   side_pin_oe_out,
  input  wire logic  [4:0]   side_pin_drive_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------------
  wire logic taken = hsel_in & hready_in & htrans_in[1];
  logic [3:0] quiet_r;
  logic [2:0] idle_r;
  // Quiet means nothing outside the divider may legally move a pin
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_r <= 4'h0;
    end else if (usb_state_in.suspend && !usb_state_in.host_out_xfer &&
                 !usb_state_in.host_in_xfer && !taken && $stable(usb_state_in) &&
                 $stable(port_pin_out)) begin
      quiet_r <= (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
    end else begin
      quiet_r <= 4'h0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_r <= 3'h0;
    end else if (taken && hwrite_in) begin
      idle_r <= 3'h0;
    end else if (idle_r != 3'h7) begin
      idle_r <= idle_r + 3'h1;
    end
  end
  resp_okay_a: assert property (hresp_out == 1'b0)
    else $error("bus response not OKAY");
  ready_high_a: assert property (hreadyout_out == 1'b1)
    else $error("slave inserted a wait state");
  rst_pins_a: assert property (disable iff (1'b0)
    !rst_n_in |-> side_pin_out == 5'h1F && side_pin_oe_out == 5'h00)
    else $error("side pins wrong during reset");
  rst_port_a: assert property (disable iff (1'b0)
    !rst_n_in |-> port_pin_out == 8'h00 && hrdata_out == 32'h0)
    else $error("port or read data wrong during reset");
  rdata_hold_a: assert property (!(taken && !hwrite_in) |=> $stable(hrdata_out))
    else $error("read data moved without a read");
  drive_hold_a: assert property (idle_r == 3'h7 |-> $stable(side_pin_drive_out))
    else $error("drive strength moved without a write");
  default_sleep_a: assert property ($rose(rst_n_in) |->
    ##[1:3] side_pin_out[4] == !usb_state_in.suspend)
    else $error("pin 4 default is not the suspend indicator");
  suspend_quiet_a: assert property (quiet_r >= 4'h8 |->
    $stable(side_pin_out) && $stable(side_pin_oe_out))
    else $error("side pin toggled while suspended");
endmodule

// ### tb/side_pin_partner.sv
// Far-side model: pulled-up side lines, a byte latch clocked by the write strobe and a read strobe counter.
// Assumes pin 0 carries the write strobe and pin 1 the read strobe.
`timescale 1ns/1ns
module side_pin_partner (
  input  wire logic [4:0] side_pin_out,
  input  wire logic [4:0] side_pin_oe_out,
  input  wire logic [7:0] port_pin_out,
  input  wire logic [7:0] port_pin_oe_out,
  input  wire logic [3:0] ext_side_in,
  input  wire logic [7:0] ext_port_in,
  output logic      [3:0] side_level_out,
  output logic      [7:0] port_level_out,
  output logic      [7:0] latch_out,
  output logic      [7:0] rd_cnt_out
);
  // Released lines show what the outside logic or pull-up puts there
  assign side_level_out = (side_pin_oe_out[3:0] & side_pin_out[3:0]) |
                          (~side_pin_oe_out[3:0] & ext_side_in);
  assign port_level_out = (port_pin_oe_out & port_pin_out) | (~port_pin_oe_out & ext_port_in);
  initial rd_cnt_out = 8'h00;
  always @(posedge side_pin_out[0]) latch_out <= port_pin_out;
  always @(posedge side_pin_out[1]) rd_cnt_out <= rd_cnt_out + 8'h01;
endmodule

// ### tb/side_pin_function_mux_bench.sv
// Self-checking bench for the side pin multiplexer.
// Assumes AHB-Lite single word transfers and a 100 MHz clock.
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module side_pin_function_mux_bench;
  import side_pin_pkg::*;
  logic clk_sys_in, rst_n_in, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  usb_state_type usb;
  logic [7:0] uart_out, uart_oe, port_in, port_out, port_oe, ext_port, latch, rd_cnt;
  logic [4:0] side_out, side_oe, side_drv;
  logic [3:0] side_in, ext_side;
  int failures, tests_run;
  side_pin_function_mux #(.STRETCH_W(`STRETCH_W)) u_dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .usb_state_in(usb),
    .uart_line_out_in(uart_out), .uart_line_oe_in(uart_oe), .port_pin_in(port_in),
    .port_pin_out(port_out), .port_pin_oe_out(port_oe), .side_pin_in(side_in),
    .side_pin_out(side_out), .side_pin_oe_out(side_oe), .side_pin_drive_out(side_drv));
  side_pin_partner u_far (.side_pin_out(side_out), .side_pin_oe_out(side_oe),
    .port_pin_out(port_out), .port_pin_oe_out(port_oe), .ext_side_in(ext_side),
    .ext_port_in(ext_port), .side_level_out(side_in), .port_level_out(port_in),
    .latch_out(latch), .rd_cnt_out(rd_cnt));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ---------------------------------------------------------------------
  // Bus and helper tasks
  // ---------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic do_reset();
    rst_n_in <= 1'b0;
    cyc(20);
    rst_n_in <= 1'b1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    bus(1'b0, `ADDR_PIN_FUNC, 32'h0, r);
    `CHK("pin4 func", FN_SUSPEND, r[19:16])
    wr(`ADDR_CHIP_ID, 32'h0);
    bus(1'b0, `ADDR_CHIP_ID, 32'h0, r);
    `CHK("chip id", `CHIP_ID_VALUE, r)
    bus(1'b0, 8'h40, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
  endtask
  task automatic t_power();
    wr(`ADDR_LED_STRETCH, 32'h4);
    wr(`ADDR_PIN_FUNC, 32'h64051);
    usb.host_configured <= 1'b1;
    usb.uart_tx_busy <= 1'b1;
    cyc(4);
    `CHK("power en", 1'b0, side_out[0])
    `CHK("sleep idle", 1'b1, side_out[1])
    `CHK("drive en", 1'b1, side_out[2])
    usb.uart_tx_busy <= 1'b0;
    wr(`ADDR_PIN_POLARITY, 32'h4);
    wr(`ADDR_PIN_DRIVE, 32'h15);
    cyc(4);
    `CHK("inverted", 1'b1, side_out[2])
    `CHK("drive", 5'h15, side_drv)
    wr(`ADDR_PIN_POLARITY, 32'h0);
  endtask
  task automatic t_clock();
    logic [3:0] h [4] = '{`HALF_48, `HALF_24, `HALF_12, `HALF_6};
    int n;
    logic p;
    for (int i = 0; i <= 4; i++) begin
      if (i == 4) usb.suspend <= 1'b1;
      else wr(`ADDR_PIN_FUNC, {12'h0, 4'(FN_CLOCK_OUT_48 + i), 16'h4051});
      cyc(4);
      n = 0;
      p = side_out[4];
      repeat (32) begin
        @(posedge clk_sys_in);
        if (side_out[4] !== p) n++;
        p = side_out[4];
      end
      `CHK("clock edges", (i == 4) ? 0 : 32 / h[i], n)
    end
    `CHK("power off", 1'b1, side_out[0])
    `CHK("sleep low", 1'b0, side_out[1])
    usb.suspend <= 1'b0;
  endtask
  task automatic t_led();
    logic [3:0] f [5] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h4};
    logic [1:0] b [5] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b01};
    logic [4:0] lo = 5'b11101;
    for (int i = 0; i < 5; i++) begin
      wr(`ADDR_PIN_FUNC, {12'h6, f[i], 12'h051});
      cyc(4);
      usb.host_out_xfer <= b[i][1];
      usb.host_in_xfer <= b[i][0];
      @(posedge clk_sys_in);
      usb.host_out_xfer <= 1'b0;
      usb.host_in_xfer <= 1'b0;
      cyc(2);
      `CHK("led pulse", !lo[i], side_out[3])
      cyc(20);
      `CHK("led idle", 1'b1, side_out[3])
    end
  endtask
  task automatic t_gpio();
    logic [31:0] r;
    wr(`ADDR_PIN_FUNC, 32'hAAACB);
    wr(`ADDR_GPIO_DIR, 32'h4);
    wr(`ADDR_GPIO_OUT, 32'h0);
    usb.uart_tx_busy <= 1'b1;
    cyc(4);
    `CHK("gpio out", 2'b10, {side_oe[2], side_out[2]})
    `CHK("pin4 gpio", 1'b1, side_out[4])
    for (int v = 0; v < 2; v++) begin
      ext_side[3] <= v[0];
      cyc(6);
      bus(1'b0, `ADDR_GPIO_IN, 32'h0, r);
      `CHK("gpio in", v[0], r[3])
    end
    usb.uart_tx_busy <= 1'b0;
  endtask
  task automatic t_bang();
    logic [31:0] r;
    logic [7:0] n0;
    `CHK("uart lines", {uart_oe, uart_out}, {port_oe, port_out})
    for (int m = 1; m < 3; m++) begin
      wr(`ADDR_BB_CTRL, {8'hFF, 2'h0, 14'h0002, 6'h00, 2'(m)});
      wr(`ADDR_BB_DATA, (m == 1) ? 32'h96 : 32'hA5);
      cyc(140);
      `CHK("port oe", 8'hFF, port_oe)
      `CHK("port byte", (m == 1) ? 8'h96 : 8'hA5, port_out)
      `CHK("write strobe", (m == 1) ? 8'h96 : 8'hA5, latch)
    end
    wr(`ADDR_BB_CTRL, {8'h0F, 2'h0, 14'h0002, 6'h00, 2'(BB_SYNC)});
    ext_port <= 8'h30;
    cyc(6);
    wr(`ADDR_BB_DATA, 32'h05);
    cyc(6);
    ext_port <= 8'hC0;
    cyc(6);
    n0 = rd_cnt;
    bus(1'b0, `ADDR_BB_READBACK, 32'h0, r);
    `CHK("sync sample", 4'h3, r[7:4])
    cyc(4);
    `CHK("read strobe", n0 + 8'h01, rd_cnt)
  endtask
  initial begin
    failures = 0;
    tests_run = 0;
    rst_n_in = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    usb = '0;
    uart_out = 8'h3C;
    uart_oe = 8'hF0;
    ext_side = 4'hF;
    ext_port = 8'h00;
    #2;
    do_reset();
    t_regs();
    t_power();
    t_clock();
    t_led();
    t_gpio();
    t_bang();
    do_reset();
    t_regs();
    end_sim();
  end
  initial begin
    cyc(20000);
    failures++;
    end_sim();
  end
endmodule
bind side_pin_function_mux side_pin_chk u_chk (.clk_sys_in, .rst_n_in, .hsel_in,
  .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
  .usb_state_in, .port_pin_out, .side_pin_out, .side_pin_oe_out, .side_pin_drive_out);
